// File: logic/fbs_cpu_end.sv
/*
 processor end: bus-init report and observe, stall signalling, issue gate.
 assumes inputs synchronous to sys_clk and power-on straps stable in reset.
*/
`timescale 1ns/10ps
// What this block does
// - drive bus init on unreliable bus condition
// - observed bus init resets lock and arbitration
// - bus init keeps in order queue contents
// - after bus init, re-arbitrate and finish queue
// - disabled observation leaves handling to central agent
// - bus init driven, sampled on fixed edges
// - assert stall when unable to accept transactions
// - owner issues nothing during a stall
// - stall line driven, sampled on fixed edges
// - refuse operation while platform qualify low
module fbs_cpu_end #(
    parameter int DEPTH = fbs_pkg::QUEUE_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst,
    fbs_link_if.cpu link,
    input wire logic init_drive_en,
    input wire logic init_observe_en,
    input wire logic platform_ok,
    input wire logic bus_error,
    input wire logic busy,
    input wire logic txn_push,
    input wire logic lock_req,
    output logic txn_issue,
    output logic bus_owned,
    output logic lock_active,
    output logic stalled,
    output logic init_seen,
    output logic [$clog2(DEPTH+1)-1:0] queue_count
);
    // ---------------------------------------------------------------
    // parameter check
    // ---------------------------------------------------------------
    localparam int CW = $clog2(DEPTH + 1);
    if (DEPTH < 1) begin : g_depth_check
        $error("DEPTH must be at least 1");
    end
    // ---------------------------------------------------------------
    // state and decode
    // ---------------------------------------------------------------
    logic phase_reg, phase_next;
    logic drv_en_reg, drv_en_next, obs_en_reg, obs_en_next;
    logic strap_done_reg, strap_done_next;
    logic init_o_reg, init_o_next, init_oe_reg, init_oe_next;
    logic bnr_o_reg, bnr_o_next, bnr_oe_reg, bnr_oe_next;
    logic stall_reg, stall_next, seen_reg, seen_next;
    logic lock_reg, lock_next, issue_reg, issue_next;
    logic owned_reg, owned_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    fbs_pkg::fbs_arb_type arb_reg, arb_next;
    logic drive_edge, sample_edge, run, init_hit, push_ok, issue_now;

    // pending transactions are held only as a count
    function automatic logic queue_full(input logic [CW-1:0] count);
        return count == CW'(DEPTH);
    endfunction

    always_comb begin
        drive_edge = (phase_reg == fbs_pkg::DRIVE_PHASE);
        sample_edge = (phase_reg == fbs_pkg::SAMPLE_PHASE);
        run = platform_ok && strap_done_reg;
        init_hit = sample_edge && !link.bus_init_n && obs_en_reg;
        push_ok = txn_push && !queue_full(cnt_reg);
        // at most one issue per two cycles, only as owner and never in a stall
        issue_now = run && !init_hit && (arb_reg == fbs_pkg::FBS_ARB_OWN) && (cnt_reg != CW'(0))
            && !stall_reg && !issue_reg;
    end

    // ---------------------------------------------------------------
    // edge phase and power-on straps
    // ---------------------------------------------------------------
    always_comb begin
        phase_next = ~phase_reg;
        strap_done_next = 1'h1;
        // straps are taken once, on the first edge after reset
        drv_en_next = strap_done_reg ? drv_en_reg : init_drive_en;
        obs_en_next = strap_done_reg ? obs_en_reg : init_observe_en;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            phase_reg <= fbs_pkg::PHASE_RESET;
            strap_done_reg <= 1'h0;
            drv_en_reg <= 1'h0;
            obs_en_reg <= 1'h0;
        end else begin
            phase_reg <= phase_next;
            strap_done_reg <= strap_done_next;
            drv_en_reg <= drv_en_next;
            obs_en_reg <= obs_en_next;
        end
    end

    // ---------------------------------------------------------------
    // wired-or line drives
    // ---------------------------------------------------------------
    always_comb begin
        init_o_next = init_o_reg;
        init_oe_next = init_oe_reg;
        bnr_o_next = bnr_o_reg;
        bnr_oe_next = bnr_oe_reg;
        // drives move only on the drive edge, then stand for two cycles
        if (drive_edge) begin
            init_oe_next = run && drv_en_reg && bus_error;
            init_o_next = ~init_oe_next;
            bnr_oe_next = run && (busy || queue_full(cnt_reg));
            bnr_o_next = ~bnr_oe_next;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            init_o_reg <= 1'h1;
            init_oe_reg <= 1'h0;
            bnr_o_reg <= 1'h1;
            bnr_oe_reg <= 1'h0;
        end else begin
            init_o_reg <= init_o_next;
            init_oe_reg <= init_oe_next;
            bnr_o_reg <= bnr_o_next;
            bnr_oe_reg <= bnr_oe_next;
        end
    end

    // ---------------------------------------------------------------
    // line sampling
    // ---------------------------------------------------------------
    always_comb begin
        stall_next = sample_edge ? !link.block_next_req_n : stall_reg;
        seen_next = init_hit ? 1'h1 : (sample_edge ? 1'h0 : seen_reg);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stall_reg <= 1'h0;
            seen_reg <= 1'h0;
        end else begin
            stall_reg <= stall_next;
            seen_reg <= seen_next;
        end
    end

    // ---------------------------------------------------------------
    // arbitration, lock and issue
    // ---------------------------------------------------------------
    always_comb begin
        arb_next = arb_reg;
        lock_next = lock_reg;
        issue_next = issue_now;
        if (!run) begin
            arb_next = fbs_pkg::FBS_ARB_HALT;
            lock_next = 1'h0;
        end else if (init_hit) begin
            // lock and arbitration restart; the queue count is left alone
            lock_next = 1'h0;
            arb_next = fbs_pkg::FBS_ARB_IDLE;
        end else begin
            unique case (arb_reg)
                fbs_pkg::FBS_ARB_HALT: arb_next = fbs_pkg::FBS_ARB_IDLE;
                fbs_pkg::FBS_ARB_IDLE: begin
                    if (cnt_reg != CW'(0)) begin
                        arb_next = fbs_pkg::FBS_ARB_REQ;
                    end
                end
                fbs_pkg::FBS_ARB_REQ: arb_next = fbs_pkg::FBS_ARB_OWN;
                fbs_pkg::FBS_ARB_OWN: begin
                    if (lock_req) begin
                        lock_next = 1'h1;
                    end
                    if (cnt_reg == CW'(0)) begin
                        arb_next = fbs_pkg::FBS_ARB_IDLE;
                        lock_next = 1'h0;
                    end
                end
            endcase
        end
        owned_next = (arb_next == fbs_pkg::FBS_ARB_OWN);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            arb_reg <= fbs_pkg::FBS_ARB_HALT;
            lock_reg <= 1'h0;
            issue_reg <= 1'h0;
            owned_reg <= 1'h0;
        end else begin
            arb_reg <= arb_next;
            lock_reg <= lock_next;
            issue_reg <= issue_next;
            owned_reg <= owned_next;
        end
    end

    // ---------------------------------------------------------------
    // pending queue count
    // ---------------------------------------------------------------
    always_comb begin
        cnt_next = cnt_reg;
        if (push_ok && !issue_now) begin
            cnt_next = cnt_reg + CW'(1);
        end else if (issue_now && !push_ok) begin
            cnt_next = cnt_reg - CW'(1);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign link.cpu_init_o = init_o_reg;
    assign link.cpu_init_oe = init_oe_reg;
    assign link.cpu_bnr_o = bnr_o_reg;
    assign link.cpu_bnr_oe = bnr_oe_reg;
    assign txn_issue = issue_reg;
    assign bus_owned = owned_reg;
    assign lock_active = lock_reg;
    assign stalled = stall_reg;
    assign init_seen = seen_reg;
    assign queue_count = cnt_reg;
endmodule

// File: logic/fbs_pkg.sv
/*
 shared constants for the front side bus init and stall signalling ends.
 assumes one bus clock shared by both ends.
*/
package fbs_pkg;
    // ---------------------------------------------------------------
    // edge phasing
    // ---------------------------------------------------------------
    // wired-or lines are driven and sampled only on every second bus clock
    localparam int EDGE_PERIOD = 2;
    localparam logic [0:0] DRIVE_PHASE = 1'h0;
    localparam logic [0:0] SAMPLE_PHASE = 1'h1;
    localparam logic [0:0] PHASE_RESET = 1'h0;
    // ---------------------------------------------------------------
    // arbitration states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        FBS_ARB_IDLE = 2'b00,
        FBS_ARB_REQ = 2'b01,
        FBS_ARB_OWN = 2'b10,
        FBS_ARB_HALT = 2'b11
    } fbs_arb_type;
    localparam int QUEUE_DEPTH = 4;
endpackage

// File: logic/fbs_link_if.sv
/*
 wired-or link between the processor end and the partner end.
 the interface itself resolves the lines from the output enables of both ends.
*/
`timescale 1ns/10ps
interface fbs_link_if;
    // ---------------------------------------------------------------
    // resolved line levels and per-end drives
    // ---------------------------------------------------------------
    logic bus_init_n;
    logic block_next_req_n;
    logic cpu_init_o;
    logic cpu_init_oe;
    logic cpu_bnr_o;
    logic cpu_bnr_oe;
    logic prt_init_o;
    logic prt_init_oe;
    logic prt_bnr_o;
    logic prt_bnr_oe;
    assign bus_init_n = ~((cpu_init_oe & ~cpu_init_o) | (prt_init_oe & ~prt_init_o));
    assign block_next_req_n = ~((cpu_bnr_oe & ~cpu_bnr_o) | (prt_bnr_oe & ~prt_bnr_o));
    modport cpu (
        input bus_init_n,
        input block_next_req_n,
        output cpu_init_o,
        output cpu_init_oe,
        output cpu_bnr_o,
        output cpu_bnr_oe
    );
    modport partner (
        input bus_init_n,
        input block_next_req_n,
        output prt_init_o,
        output prt_init_oe,
        output prt_bnr_o,
        output prt_bnr_oe
    );
endinterface

// File: logic/fbs_partner_end.sv
/*
 partner end: chipset side of bus init and stall lines.
 assumes inputs synchronous to sys_clk, same edge phasing as the processor.
*/
`timescale 1ns/10ps
module fbs_partner_end (
    input wire logic sys_clk,
    input wire logic rst,
    fbs_link_if.partner link,
    input wire logic raise_init,
    input wire logic busy,
    output logic init_event,
    output logic stall_seen
);
    logic phase_reg, phase_next;
    logic init_o_reg, init_o_next, init_oe_reg, init_oe_next;
    logic bnr_o_reg, bnr_o_next, bnr_oe_reg, bnr_oe_next;
    logic evt_reg, evt_next, stl_reg, stl_next;
    logic drive_edge, sample_edge;

    always_comb begin
        drive_edge = (phase_reg == fbs_pkg::DRIVE_PHASE);
        sample_edge = (phase_reg == fbs_pkg::SAMPLE_PHASE);
        phase_next = ~phase_reg;
        init_o_next = init_o_reg;
        init_oe_next = init_oe_reg;
        bnr_o_next = bnr_o_reg;
        bnr_oe_next = bnr_oe_reg;
        if (drive_edge) begin
            init_oe_next = raise_init;
            init_o_next = ~raise_init;
            bnr_oe_next = busy;
            bnr_o_next = ~busy;
        end
        // observed assertion is reported to the error handler as a pulse
        evt_next = sample_edge && !link.bus_init_n;
        stl_next = sample_edge ? !link.block_next_req_n : stl_reg;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            phase_reg <= fbs_pkg::PHASE_RESET;
            init_o_reg <= 1'h1;
            init_oe_reg <= 1'h0;
            bnr_o_reg <= 1'h1;
            bnr_oe_reg <= 1'h0;
            evt_reg <= 1'h0;
            stl_reg <= 1'h0;
        end else begin
            phase_reg <= phase_next;
            init_o_reg <= init_o_next;
            init_oe_reg <= init_oe_next;
            bnr_o_reg <= bnr_o_next;
            bnr_oe_reg <= bnr_oe_next;
            evt_reg <= evt_next;
            stl_reg <= stl_next;
        end
    end

    assign link.prt_init_o = init_o_reg;
    assign link.prt_init_oe = init_oe_reg;
    assign link.prt_bnr_o = bnr_o_reg;
    assign link.prt_bnr_oe = bnr_oe_reg;
    assign init_event = evt_reg;
    assign stall_seen = stl_reg;
endmodule

// File: sim/fbs_link_assertions.sv
/*
 checker for the bus init and stall wired-or lines of the link.
 assumes instantiation beside the link interface, fed its signals.
*/
`timescale 1ns/10ps
module fbs_link_assertions (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic bus_init_n,
    input wire logic block_next_req_n,
    input wire logic cpu_init_oe,
    input wire logic cpu_bnr_oe,
    input wire logic prt_init_oe,
    input wire logic prt_bnr_oe
);
    // ---------------------------------------------------------------
    // edge phase tracker
    // ---------------------------------------------------------------
    logic phase_reg;
    logic phase_next;
    always_comb begin
        phase_next = ~phase_reg;
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            phase_reg <= fbs_pkg::PHASE_RESET;
        end else begin
            phase_reg <= phase_next;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_cpu_init_edge: assert property (phase_reg == fbs_pkg::DRIVE_PHASE |-> $stable(cpu_init_oe))
        else $error("cpu init drive changed off its edge");
    a_cpu_bnr_edge: assert property (phase_reg == fbs_pkg::DRIVE_PHASE |-> $stable(cpu_bnr_oe))
        else $error("cpu stall drive changed off its edge");
    a_prt_init_edge: assert property (!$stable(prt_init_oe) |-> phase_reg != fbs_pkg::DRIVE_PHASE)
        else $error("partner init drive changed off its edge");
    a_prt_bnr_edge: assert property (!$stable(prt_bnr_oe) |-> phase_reg != fbs_pkg::DRIVE_PHASE)
        else $error("partner stall drive changed off its edge");
    a_init_line_edge: assert property ($changed(bus_init_n) |-> phase_reg == fbs_pkg::SAMPLE_PHASE)
        else $error("bus init line moved off its edge");
    a_bnr_line_edge: assert property ($changed(block_next_req_n) |-> phase_reg == fbs_pkg::SAMPLE_PHASE)
        else $error("stall line moved off its edge");
    a_init_hold_two: assert property ($rose(cpu_init_oe) |=> cpu_init_oe)
        else $error("cpu init drive held under two cycles");
    a_bnr_line_hold: assert property ($fell(block_next_req_n) |=> !block_next_req_n)
        else $error("stall line held under two cycles");
endmodule

// File: sim/tb_top.sv
/*
 bench joining processor and partner ends over the link.
 assumes nothing beyond the design and checker files.
*/
`timescale 1ns/10ps
module tb_top;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic init_drive_en = 1'b1, init_observe_en = 1'b1, platform_ok = 1'b1, bus_error = 1'b0, busy = 1'b0;
    logic txn_push = 1'b0, lock_req = 1'b0, raise_init = 1'b0, prt_busy = 1'b0;
    logic txn_issue, bus_owned, lock_active, stalled, init_seen, init_event, stall_seen;
    logic [2:0] queue_count;
    int miscompares = 0, comparisons = 0, cycles = 0, issues = 0, events = 0, seen_cnt = 0, i0, s0;
    logic [1:0] row_in [4] = '{2'b00, 2'b10, 2'b01, 2'b11};
    logic [2:0] row_exp [4] = '{3'b100, 3'b011, 3'b011, 3'b011};
    fbs_link_if link ();
    fbs_cpu_end fbs_cpu_end_inst (.sys_clk(sys_clk), .rst(rst), .link(link), .init_drive_en(init_drive_en),
        .init_observe_en(init_observe_en), .platform_ok(platform_ok), .bus_error(bus_error), .busy(busy),
        .txn_push(txn_push), .lock_req(lock_req), .txn_issue(txn_issue), .bus_owned(bus_owned),
        .lock_active(lock_active), .stalled(stalled), .init_seen(init_seen), .queue_count(queue_count));
    fbs_partner_end fbs_partner_end_inst (.sys_clk(sys_clk), .rst(rst), .link(link), .raise_init(raise_init),
        .busy(prt_busy), .init_event(init_event), .stall_seen(stall_seen));
    fbs_link_assertions fbs_link_assertions_inst (.sys_clk(sys_clk), .rst(rst), .bus_init_n(link.bus_init_n),
        .block_next_req_n(link.block_next_req_n), .cpu_init_oe(link.cpu_init_oe), .cpu_bnr_oe(link.cpu_bnr_oe),
        .prt_init_oe(link.prt_init_oe), .prt_bnr_oe(link.prt_bnr_oe));
    always #4 sys_clk = ~sys_clk;
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic print_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic push();
        txn_push = 1'b1;
        cyc(1);
        txn_push = 1'b0;
        cyc(1);
    endtask
    task automatic drain();
        for (int i = 0; i < 40 && queue_count !== 3'h0; i++) cyc(1);
    endtask
    task automatic do_reset(input logic drv, input logic obs);
        rst = 1'b1;
        init_drive_en = drv;
        init_observe_en = obs;
        cyc(10);
        check({link.cpu_init_oe, link.cpu_bnr_oe, link.prt_bnr_oe, txn_issue, queue_count}, 8'h00, "reset");
        rst = 1'b0;
        cyc(4);
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (txn_issue === 1'b1) issues++;
        if (init_event === 1'b1) events++;
        if (init_seen === 1'b1) seen_cnt++;
        if (cycles == 3000) begin
            miscompares++;
            print_verdict();
        end
    end
    initial begin
        do_reset(1'b1, 1'b1);
        for (int r = 0; r < 4; r++) begin
            {busy, prt_busy} = row_in[r];
            cyc(6);
            check({link.block_next_req_n, stalled, stall_seen}, row_exp[r], "stall row");
        end
        $display("done rows");
        {busy, prt_busy} = 2'b01;
        cyc(4);
        i0 = issues;
        push();
        push();
        lock_req = 1'b1;
        cyc(12);
        check(issues, i0, "issue under stall");
        check(lock_active, 1'b1, "lock set");
        $display("done stall");
        bus_error = 1'b1;
        lock_req = 1'b0;
        cyc(4);
        check(link.bus_init_n, 1'b0, "init driven");
        bus_error = 1'b0;
        cyc(6);
        check(lock_active, 1'b0, "lock reset");
        check(queue_count, 3'h2, "queue kept");
        check(seen_cnt > 0, 1'b1, "init observed");
        check(events > 0, 1'b1, "partner saw init");
        prt_busy = 1'b0;
        drain();
        cyc(4);
        check(queue_count, 3'h0, "queue drained");
        check(issues, i0 + 2, "resumed issue");
        $display("done bus init");
        platform_ok = 1'b0;
        cyc(4);
        push();
        cyc(12);
        check({bus_owned, 7'(issues - i0)}, 8'h02, "refused");
        platform_ok = 1'b1;
        drain();
        cyc(4);
        check(issues, i0 + 3, "accepted");
        $display("done platform");
        do_reset(1'b0, 1'b0);
        bus_error = 1'b1;
        cyc(8);
        check(link.bus_init_n, 1'b1, "drive disabled");
        bus_error = 1'b0;
        i0 = events;
        s0 = seen_cnt;
        raise_init = 1'b1;
        cyc(8);
        check(link.bus_init_n, 1'b0, "partner init");
        raise_init = 1'b0;
        cyc(6);
        check(seen_cnt, s0, "observe disabled");
        check(events > i0, 1'b1, "central handles");
        $display("done straps");
        print_verdict();
    end
endmodule
